/* include/auxcv_map.svh */
// register offsets, field positions, reset values and timing in nanoseconds of the auxiliary converter control
// assumes a 200 MHz ref_clk and an 8-bit register address on the serial control port
`ifndef AUXCV_MAP_SVH
`define AUXCV_MAP_SVH
`define AUXCV_ADDR_SRC_MODE 8'ha7
`define AUXCV_ADDR_DAC_CTRL 8'ha8
`define AUXCV_ADDR_ADC1_RES 8'ha9
`define AUXCV_ADDR_ADC2_RES 8'haa
`define AUXCV_ADDR_THRESH 8'hb5
`define AUXCV_ADDR_STATUS 8'hc6
`define AUXCV_ADDR_IRQ_MASK 8'hce
`define AUXCV_SRC1_LSB 2
`define AUXCV_AVG1_LSB 5
`define AUXCV_SRC2_LSB 7
`define AUXCV_AVG2_LSB 10
`define AUXCV_DAC_RAMP_BIT 12
`define AUXCV_DAC_EN_BIT 11
`define AUXCV_DAC_CH_LSB 13
`define AUXCV_THR_HIGH_BIT 12
`define AUXCV_THR_CH_BIT 13
`define AUXCV_ST_IRQ_BIT 15
`define AUXCV_ST_PRG_BIT 0
`define AUXCV_ST_ADC1_BIT 1
`define AUXCV_ST_ADC2_BIT 2
`define AUXCV_RES_HI_BIT 15
`define AUXCV_RES_LO_BIT 14
`define AUXCV_AVG_LEN_RESET 4'h0
`define AUXCV_AVG_LEN_MAX 4'h8
`define AUXCV_SAMPLE_NS 250000
`define AUXCV_RAMP_STEP_NS 10000
`define AUXCV_CLK_NS 5
`endif

/* include/auxcv_pkg.sv */
// types shared by the auxiliary converter control
// assumes auxcv_map.svh is on the include path
package auxcv_pkg;
  typedef logic [9:0] auxcv_sample_t;
  typedef enum logic [1:0] {AUXCV_RAMP_IDLE, AUXCV_RAMP_UP, AUXCV_RAMP_HOLD} auxcv_ramp_e;
endpackage

/* verilog/auxcv_adc_chan.sv */
// one auxiliary ADC channel: averaging and threshold comparison
// assumes sample_valid pulses once per finished conversion on ref_clk
`timescale 1ns/1ps
`default_nettype none
`include "auxcv_map.svh"
module auxcv_adc_chan
  import auxcv_pkg::*;
#(
  parameter int WIDTH = 10
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic sample_valid,
  input wire logic [WIDTH-1:0] sample,
  input wire logic avg_en,
  input wire logic [3:0] avg_len,
  input wire logic [WIDTH-1:0] thr_high,
  input wire logic [WIDTH-1:0] thr_low,
  output logic [WIDTH-1:0] value,
  output logic above_high,
  output logic below_low,
  output logic cross_event
);
  if (WIDTH < 2 || WIDTH > 14) begin : g_bad_width
    $error("auxcv_adc_chan: WIDTH out of range");
  end

  typedef struct packed {
    logic [WIDTH+8:0] acc;
    logic above;
    logic below;
    logic evt;
  } auxcv_chan_s;

  auxcv_chan_s cur;
  auxcv_chan_s nxt;
  logic [WIDTH+8:0] samp_ext;
  logic [WIDTH+8:0] step;
  logic [3:0] len_eff;
  logic [WIDTH-1:0] new_val;
  logic new_above;
  logic new_below;

  always_comb begin
    nxt = cur;
    nxt.evt = 1'b0;
    len_eff = (avg_len > `AUXCV_AVG_LEN_MAX) ? `AUXCV_AVG_LEN_MAX : avg_len;
    samp_ext = {sample, 9'h000};
    new_val = sample;
    new_above = cur.above;
    new_below = cur.below;
    step = '0;
    if (sample_valid) begin
      if (avg_en) begin
        // rolling: acc += (samp - acc) / 2^(n+1), starting from current value
        if (samp_ext >= cur.acc) begin
          step = (samp_ext - cur.acc) >> (len_eff + 4'h1);
          nxt.acc = cur.acc + step;
        end else begin
          step = (cur.acc - samp_ext) >> (len_eff + 4'h1);
          nxt.acc = cur.acc - step;
        end
      end else begin
        nxt.acc = samp_ext;
      end
      new_val = nxt.acc[WIDTH+8:9];
      new_above = new_val > thr_high;
      new_below = new_val < thr_low;
      // fire only on the crossing sample
      nxt.evt = (new_above && !cur.above) || (new_below && !cur.below);
      nxt.above = new_above;
      nxt.below = new_below;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  assign value = cur.acc[WIDTH+8:9];
  assign above_high = cur.above;
  assign below_low = cur.below;
  assign cross_event = cur.evt;

  AST_EVT_ONLY_AFTER_SAMPLE: assert property (@(posedge ref_clk) disable iff (!arst_n)
    cross_event |-> $past(sample_valid)) else $error("crossing event without a sample");
  AST_NO_AVG_TRACKS: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (sample_valid && !avg_en) |=> value == $past(sample)) else $error("unaveraged value wrong");
  AST_RISE_EVT: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (sample_valid && !above_high) ##1 above_high |-> cross_event) else $error("missed high crossing");
endmodule
`default_nettype wire

/* verilog/auxcv_top.sv */
// auxiliary ADC and DAC control behind the serial control port registers
// assumes the port logic presents decoded one-cycle write and read strobes on ref_clk,
// converter results arrive from the analogue side as pin inputs, source and averaging selects come from the mode register, tx_mode and powersave from pins
`timescale 1ns/1ps
`default_nettype none
`include "auxcv_map.svh"
module auxcv_top
  import auxcv_pkg::*;
#(
  parameter int WIDTH = 10,
  parameter int PROFILE_LEN = 32,
  parameter int SAMPLE_CYCLES = (`AUXCV_SAMPLE_NS + `AUXCV_CLK_NS - 1) / `AUXCV_CLK_NS,
  parameter int RAMP_CYCLES = `AUXCV_RAMP_STEP_NS / `AUXCV_CLK_NS
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] wr_data,
  output logic [15:0] rd_data,
  input wire logic prof_wr,
  input wire logic [4:0] prof_addr,
  input wire logic [WIDTH-1:0] prof_data,
  input wire logic program_ready_flag,
  input wire logic tx_mode,
  input wire logic powersave,
  input wire logic [3:0] avg_len,
  input wire logic [4*WIDTH-1:0] pin_samples,
  input wire logic [3:0] pin_done,
  output logic [1:0] adc_run,
  output logic [4*WIDTH-1:0] dac_level,
  output logic [15:0] status_flags,
  output logic interrupt_out_n
);
  if (PROFILE_LEN != 32 || WIDTH < 2 || WIDTH > 11) begin : g_bad_size
    $error("auxcv_top: PROFILE_LEN must be 32 and WIDTH 2 to 11");
  end
  if (SAMPLE_CYCLES < 1 || SAMPLE_CYCLES > 262144 || RAMP_CYCLES < 1 || RAMP_CYCLES > 65536) begin : g_bad_timing
    $error("auxcv_top: bad timing");
  end

  typedef struct packed {
    logic [15:0] mode;
    logic [3:0][WIDTH-1:0] dac;
    logic [3:0] dac_en;
    logic [1:0][WIDTH-1:0] thr_hi;
    logic [1:0][WIDTH-1:0] thr_lo;
    logic [15:0] flags;
    logic [15:0] mask;
    logic [15:0] rdata;
    logic [3:0][WIDTH-1:0] dac_out;
    logic [1:0][17:0] tick;
    logic [1:0] run;
    logic [1:0] valid;
    auxcv_ramp_e ramp;
    logic [4:0] ramp_idx;
    logic [15:0] ramp_cnt;
    logic irq_n;
    logic [3:0] done_s1;
    logic [3:0] done_s2;
    logic [4*WIDTH-1:0] samp_s1;
    logic [4*WIDTH-1:0] samp_s2;
  } auxcv_top_s;

  auxcv_top_s cur;
  auxcv_top_s nxt;
  logic [WIDTH-1:0] profile [0:31];
  logic [1:0][WIDTH-1:0] ch_value;
  logic [1:0] ch_hi;
  logic [1:0] ch_lo;
  logic [1:0] ch_evt;
  logic [1:0][2:0] src_sel;
  logic [1:0] avg_sel;

  // raised cosine default (cubic s-curve fit), overwritable by the program block path
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 32; i++) begin
        profile[i] <= WIDTH'(((93 * i * i - 2 * i * i * i) * ((1 << WIDTH) - 1)) / 29791);
      end
    end else if (prof_wr) begin
      profile[prof_addr] <= prof_data;
    end
  end

  assign src_sel[0] = cur.mode[`AUXCV_SRC1_LSB +: 3];
  assign src_sel[1] = cur.mode[`AUXCV_SRC2_LSB +: 3];
  assign avg_sel[0] = |cur.mode[`AUXCV_AVG1_LSB +: 2];
  assign avg_sel[1] = |cur.mode[`AUXCV_AVG2_LSB +: 2];

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      logic [WIDTH-1:0] sel_sample;
      // independent input routing per channel, code 0 is none
      always_comb begin
        sel_sample = '0;
        if (src_sel[g] != 3'h0 && src_sel[g] <= 3'h4) begin
          sel_sample = cur.samp_s2[(32'(src_sel[g]) - 1) * WIDTH +: WIDTH];
        end
      end
      auxcv_adc_chan #(.WIDTH(WIDTH)) u_chan (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .sample_valid(cur.valid[g]),
        .sample(sel_sample),
        .avg_en(avg_sel[g]),
        .avg_len(avg_len),
        .thr_high(cur.thr_hi[g]),
        .thr_low(cur.thr_lo[g]),
        .value(ch_value[g]),
        .above_high(ch_hi[g]),
        .below_low(ch_lo[g]),
        .cross_event(ch_evt[g])
      );
    end
  endgenerate

  always_comb begin
    nxt = cur;
    nxt.done_s1 = pin_done;
    nxt.done_s2 = cur.done_s1;
    nxt.samp_s1 = pin_samples;
    nxt.samp_s2 = cur.samp_s1;
    nxt.valid = '0;
    for (int c = 0; c < 2; c++) begin
      // conversion pacing while a source is selected
      nxt.run[c] = src_sel[c] != 3'h0 && src_sel[c] <= 3'h4;
      if (!cur.run[c]) begin
        nxt.tick[c] = '0;
      end else if (cur.tick[c] >= 18'(SAMPLE_CYCLES - 1)) begin
        nxt.tick[c] = '0;
        nxt.valid[c] = 1'b1;
      end else begin
        nxt.tick[c] = cur.tick[c] + 18'h1;
      end
    end
    // ramp stepping first, so a channel 0 write below restarts or stops it
    case (cur.ramp)
      AUXCV_RAMP_UP: begin
        if (!tx_mode) begin
          nxt.ramp = AUXCV_RAMP_IDLE;
        end else if (cur.ramp_cnt >= 16'(RAMP_CYCLES - 1)) begin
          nxt.ramp_cnt = '0;
          if (cur.ramp_idx == 5'h1f) begin
            nxt.ramp = AUXCV_RAMP_HOLD;
          end else begin
            nxt.ramp_idx = cur.ramp_idx + 5'h1;
          end
        end else begin
          nxt.ramp_cnt = cur.ramp_cnt + 16'h1;
        end
      end
      AUXCV_RAMP_HOLD: begin
        if (!tx_mode) begin
          nxt.ramp = AUXCV_RAMP_IDLE;
        end
      end
      AUXCV_RAMP_IDLE: begin
      end
      default: nxt.ramp = AUXCV_RAMP_IDLE;
    endcase
    if (wr_stb) begin
      case (reg_addr)
        `AUXCV_ADDR_SRC_MODE: nxt.mode = wr_data;
        `AUXCV_ADDR_DAC_CTRL: begin
          // one channel per write
          nxt.dac[wr_data[`AUXCV_DAC_CH_LSB +: 2]] = wr_data[WIDTH-1:0];
          nxt.dac_en[wr_data[`AUXCV_DAC_CH_LSB +: 2]] = wr_data[`AUXCV_DAC_EN_BIT];
          if (wr_data[`AUXCV_DAC_CH_LSB +: 2] == 2'h0) begin
            nxt.ramp = (wr_data[`AUXCV_DAC_RAMP_BIT] && tx_mode) ? AUXCV_RAMP_UP : AUXCV_RAMP_IDLE;
            nxt.ramp_idx = '0;
            nxt.ramp_cnt = '0;
          end
        end
        `AUXCV_ADDR_THRESH: begin
          if (wr_data[`AUXCV_THR_HIGH_BIT]) begin
            nxt.thr_hi[wr_data[`AUXCV_THR_CH_BIT]] = wr_data[WIDTH-1:0];
          end else begin
            nxt.thr_lo[wr_data[`AUXCV_THR_CH_BIT]] = wr_data[WIDTH-1:0];
          end
        end
        `AUXCV_ADDR_IRQ_MASK: nxt.mask = wr_data;
        default: begin
        end
      endcase
    end
    for (int d = 0; d < 4; d++) begin
      if (powersave && !cur.dac_en[d]) begin
        nxt.dac_out[d] = '0;
      end else if (d == 0 && cur.ramp != AUXCV_RAMP_IDLE) begin
        nxt.dac_out[d] = profile[cur.ramp_idx];
      end else if (cur.dac_en[d]) begin
        nxt.dac_out[d] = cur.dac[d];
      end else begin
        nxt.dac_out[d] = '0;
      end
    end
    nxt.flags[`AUXCV_ST_PRG_BIT] = program_ready_flag;
    if (rd_stb && reg_addr == `AUXCV_ADDR_STATUS) begin
      nxt.flags[15:1] = '0;
    end
    // set wins over the read clear
    if (ch_evt[0]) nxt.flags[`AUXCV_ST_ADC1_BIT] = 1'b1;
    if (ch_evt[1]) nxt.flags[`AUXCV_ST_ADC2_BIT] = 1'b1;
    if (|(ch_evt & cur.mask[2:1])) nxt.flags[`AUXCV_ST_IRQ_BIT] = 1'b1;
    if (|(cur.flags[14:0] & ~cur.mask[14:0] & nxt.mask[14:0])) nxt.flags[`AUXCV_ST_IRQ_BIT] = 1'b1;
    nxt.irq_n = !(nxt.flags[`AUXCV_ST_IRQ_BIT] && nxt.mask[`AUXCV_ST_IRQ_BIT]);
    nxt.rdata = '0;
    if (rd_stb) begin
      case (reg_addr)
        `AUXCV_ADDR_ADC1_RES: nxt.rdata = {ch_hi[0], ch_lo[0], (14 - WIDTH)'(0), ch_value[0]};
        `AUXCV_ADDR_ADC2_RES: nxt.rdata = {ch_hi[1], ch_lo[1], (14 - WIDTH)'(0), ch_value[1]};
        `AUXCV_ADDR_STATUS: nxt.rdata = cur.flags;
        default: nxt.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cur <= '0;
      cur.irq_n <= 1'b1;
      cur.ramp <= AUXCV_RAMP_IDLE;
    end else begin
      cur <= nxt;
    end
  end

  assign rd_data = cur.rdata;
  assign adc_run = cur.run;
  assign dac_level = cur.dac_out;
  assign status_flags = cur.flags;
  assign interrupt_out_n = cur.irq_n;

  sequence s_status_read;
    rd_stb && reg_addr == `AUXCV_ADDR_STATUS && ch_evt == 2'b00;
  endsequence

  AST_STATUS_CLEAR: assert property (@(posedge ref_clk) disable iff (!arst_n)
    s_status_read |=> status_flags[14:1] == '0) else $error("status read did not clear");
  AST_STOP_AT_NONE: assert property (@(posedge ref_clk) disable iff (!arst_n)
    src_sel[0] == 3'h0 |=> !adc_run[0]) else $error("channel runs with no source");
  AST_RAMP_TX_ONLY: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !tx_mode |=> cur.ramp == AUXCV_RAMP_IDLE) else $error("ramp outside transmit");
  AST_PSAVE_ZERO: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (powersave && !cur.dac_en[3]) |=> dac_level[4*WIDTH-1:3*WIDTH] == '0) else $error("disabled dac not zero");
  AST_MASK_LATE: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (wr_stb && reg_addr == `AUXCV_ADDR_IRQ_MASK && wr_data[15] && wr_data[1] && status_flags[1] && !cur.mask[1])
    |=> !interrupt_out_n) else $error("late mask did not raise interrupt");
  AST_DAC_ONE_CH: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (wr_stb && reg_addr == `AUXCV_ADDR_DAC_CTRL && wr_data[14:13] == 2'h3)
    |=> cur.dac[0] == $past(cur.dac[0])) else $error("dac write touched other channel");
  AST_EVT_FLAG: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ch_evt[0] |=> status_flags[1]) else $error("crossing not flagged");
  AST_RESULT_READ: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (rd_stb && reg_addr == `AUXCV_ADDR_ADC1_RES) |=> rd_data[WIDTH-1:0] == $past(ch_value[0]))
    else $error("result read wrong");
endmodule
`default_nettype wire

/* tb/auxcv_host.sv */
// host side of the register port: one-cycle write and read strobes
// assumes stimulus changes at the falling edge and the port takes requests at the rising edge
`timescale 1ns/1ps
`default_nettype none
module auxcv_host (
  input wire logic ref_clk,
  output logic wr_stb,
  output logic rd_stb,
  output logic [7:0] reg_addr,
  output logic [15:0] wr_data,
  input wire logic [15:0] rd_data
);
  initial begin
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    reg_addr = 8'h00;
    wr_data = 16'h0000;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(negedge ref_clk);
    reg_addr = a;
    wr_data = v;
    wr_stb = 1'b1;
    @(negedge ref_clk);
    wr_stb = 1'b0;
    wr_data = ~v;
  endtask
  // read data is registered at the taking edge, sampled one half cycle later
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    rd_stb = 1'b1;
    @(negedge ref_clk);
    d = rd_data;
    rd_stb = 1'b0;
  endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
// self-checking bench of the auxiliary converter control
// assumes shortened sample and ramp counts and a host model driving the register port
`timescale 1ns/1ps
`default_nettype none
`include "auxcv_map.svh"
module tb;
  localparam int W = 10;
  localparam int PL = 32;
  localparam int RC = 2;
  logic ref_clk, arst_n, wr_stb, rd_stb, prof_wr, program_ready_flag, tx_mode, powersave, interrupt_out_n;
  logic [7:0] reg_addr;
  logic [15:0] wr_data, rd_data, status_flags, d;
  logic [4:0] prof_addr;
  logic [W-1:0] prof_data, v0;
  logic [3:0] avg_len, pin_done;
  logic [4*W-1:0] pin_samples, dac_level;
  logic [1:0] adc_run;
  logic [31:0] lfsr;
  int num_errors, n_checks, s, n, c, k;
  int dac_m[4];
  int lens[5] = '{0, 1, 2, 8, 9};
  auxcv_host host (.ref_clk(ref_clk), .wr_stb(wr_stb), .rd_stb(rd_stb), .reg_addr(reg_addr),
    .wr_data(wr_data), .rd_data(rd_data));
  auxcv_top #(.WIDTH(W), .PROFILE_LEN(PL), .SAMPLE_CYCLES(8), .RAMP_CYCLES(RC)) dut (.ref_clk(ref_clk),
    .arst_n(arst_n), .wr_stb(wr_stb), .rd_stb(rd_stb), .reg_addr(reg_addr), .wr_data(wr_data),
    .rd_data(rd_data), .prof_wr(prof_wr), .prof_addr(prof_addr), .prof_data(prof_data),
    .program_ready_flag(program_ready_flag), .tx_mode(tx_mode), .powersave(powersave), .avg_len(avg_len),
    .pin_samples(pin_samples), .pin_done(pin_done), .adc_run(adc_run), .dac_level(dac_level),
    .status_flags(status_flags), .interrupt_out_n(interrupt_out_n));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // polls a result until it equals v (want=1) or differs from v (want=0)
  task automatic poll(input int ch, input logic [W-1:0] v, input bit want, output logic [15:0] r);
    for (int i = 0; i < 60; i++) begin
      host.rd(ch ? `AUXCV_ADDR_ADC2_RES : `AUXCV_ADDR_ADC1_RES, r);
      if ((r[W-1:0] === v) == want) break;
    end
  endtask
  task automatic pin(input int i, input logic [W-1:0] v);
    pin_samples[i*W +: W] = v;
  endtask
  task automatic rnd();
    lfsr = lfsr_next(lfsr);
  endtask
  task automatic chk_dac();
    for (int i = 0; i < 4; i++) chk(16'(dac_level[i*W +: W]), 16'(dac_m[i]));
  endtask
  initial begin
    repeat (60000) @(posedge ref_clk);
    num_errors++;
    stop_test();
  end
  initial begin
    arst_n = 1'b0; prof_wr = 1'b0; prof_addr = 5'h00; prof_data = '0; program_ready_flag = 1'b1;
    tx_mode = 1'b0; powersave = 1'b0; avg_len = 4'h0; pin_samples = '0; pin_done = 4'h0;
    lfsr = 32'he1b8; num_errors = 0; n_checks = 0; dac_m = '{0, 0, 0, 0};
    repeat (2) @(negedge ref_clk);
    arst_n = 1'b1;
    host.rd(8'h55, d);
    chk(d, 16'h0000);
    // independent sources on both channels
    pin(0, lfsr[9:0]); pin(1, ~lfsr[9:0]); pin(2, lfsr[19:10]); pin(3, ~lfsr[19:10]);
    host.wr(`AUXCV_ADDR_SRC_MODE, (16'h1 << `AUXCV_SRC1_LSB) | (16'h3 << `AUXCV_SRC2_LSB)); // bias taken as on
    @(negedge ref_clk);
    chk({14'h0, adc_run}, 16'h0003);
    poll(0, lfsr[9:0], 1, d);
    chk(16'(d[W-1:0]), 16'(lfsr[9:0]));
    poll(1, lfsr[19:10], 1, d);
    chk(16'(d[W-1:0]), 16'(lfsr[19:10]));
    host.wr(`AUXCV_ADDR_SRC_MODE, 16'h1 << `AUXCV_SRC1_LSB);
    @(negedge ref_clk);
    chk({14'h0, adc_run}, 16'h0001);
    // rolling average from the converted value, clamped length
    foreach (lens[j]) begin
      rnd();
      v0 = {1'b0, lfsr[8:0]};
      avg_len = 4'h0;
      host.wr(`AUXCV_ADDR_SRC_MODE, 16'h1 << `AUXCV_SRC1_LSB);
      pin(0, v0);
      poll(0, v0, 1, d);
      chk(16'(d[W-1:0]), 16'(v0));
      avg_len = 4'(lens[j]);
      n = lens[j] > 8 ? 8 : lens[j];
      host.wr(`AUXCV_ADDR_SRC_MODE, (16'h1 << `AUXCV_SRC1_LSB) | (16'h1 << `AUXCV_AVG1_LSB));
      pin(0, v0 ^ 10'h200);
      s = int'(v0) <<< 9;
      repeat (3) begin
        k = int'(d[W-1:0]);
        poll(0, d[W-1:0], 0, d);
        // a sample may move only the fraction bits, so step until the shown value moves
        do begin
          s = s + (((int'(v0 ^ 10'h200) <<< 9) - s) >>> (n + 1));
        end while ((s >>> 9) == k);
        chk(16'(d[W-1:0]), 16'(s >>> 9));
      end
    end
    // thresholds, crossing flags and interrupt
    avg_len = 4'h0;
    host.wr(`AUXCV_ADDR_SRC_MODE, 16'h1 << `AUXCV_SRC1_LSB);
    host.wr(`AUXCV_ADDR_THRESH, (16'h1 << `AUXCV_THR_HIGH_BIT) | 16'd400);
    host.wr(`AUXCV_ADDR_THRESH, 16'd100);
    pin(0, 10'd200);
    poll(0, 10'd200, 1, d);
    host.rd(`AUXCV_ADDR_STATUS, d);
    pin(0, 10'd500);
    poll(0, 10'd500, 1, d);
    chk(d, 16'h8000 | 16'd500);
    chk(status_flags, 16'h0003);
    chk({15'h0, interrupt_out_n}, 16'h0001);
    host.wr(`AUXCV_ADDR_IRQ_MASK, 16'h8002);
    @(negedge ref_clk);
    chk(status_flags, 16'h8003);
    chk({15'h0, interrupt_out_n}, 16'h0000);
    host.rd(`AUXCV_ADDR_STATUS, d);
    chk(d, 16'h8003);
    @(negedge ref_clk);
    chk(status_flags, 16'h0001);
    chk({15'h0, interrupt_out_n}, 16'h0001);
    repeat (24) @(negedge ref_clk);
    chk(status_flags, 16'h0001);
    pin(0, 10'd250);
    poll(0, 10'd250, 1, d);
    chk(d, 16'd250);
    chk(status_flags, 16'h0001);
    pin(0, 10'd50);
    poll(0, 10'd50, 1, d);
    chk(d, 16'h4000 | 16'd50);
    chk(status_flags, 16'h8003);
    chk({15'h0, interrupt_out_n}, 16'h0000);
    host.rd(`AUXCV_ADDR_STATUS, d);
    // one channel per write, powersave zero
    for (c = 0; c < 4; c++) begin
      rnd();
      dac_m[c] = int'(lfsr[9:0]);
      host.wr(`AUXCV_ADDR_DAC_CTRL, (16'(c) << `AUXCV_DAC_CH_LSB) | (16'h1 << `AUXCV_DAC_EN_BIT) | 16'(lfsr[9:0]));
      @(negedge ref_clk);
      chk_dac();
    end
    host.wr(`AUXCV_ADDR_DAC_CTRL, (16'h3 << `AUXCV_DAC_CH_LSB) | 16'(dac_m[3]));
    powersave = 1'b1;
    dac_m[3] = 0;
    repeat (2) @(negedge ref_clk);
    chk_dac();
    powersave = 1'b0;
    // default profile ramp: starts at zero, ends at full scale
    tx_mode = 1'b1;
    host.wr(`AUXCV_ADDR_DAC_CTRL, (16'h1 << `AUXCV_DAC_RAMP_BIT) | (16'h1 << `AUXCV_DAC_EN_BIT));
    @(negedge ref_clk);
    chk(16'(dac_level[W-1:0]), 16'h0000);
    repeat (PL * RC * 2 + 20) @(negedge ref_clk);
    chk(16'(dac_level[W-1:0]), 16'((1 << W) - 1));
    tx_mode = 1'b0;
    @(negedge ref_clk);
    // user profile, then a ramp in transmit
    prof_wr = 1'b1;
    for (k = 0; k < PL; k++) begin
      prof_addr = 5'(k);
      prof_data = W'(k * 16);
      @(negedge ref_clk);
    end
    prof_wr = 1'b0;
    tx_mode = 1'b1;
    host.wr(`AUXCV_ADDR_DAC_CTRL, (16'h1 << `AUXCV_DAC_RAMP_BIT) | (16'h1 << `AUXCV_DAC_EN_BIT));
    // one profile step every RC cycles, output one cycle behind the index
    repeat (11) @(negedge ref_clk);
    chk(16'(dac_level[W-1:0]), 16'(5 * 16));
    repeat (PL * RC * 2) @(negedge ref_clk);
    chk(16'(dac_level[W-1:0]), 16'((PL - 1) * 16));
    tx_mode = 1'b0;
    // ramp request outside transmit acts as a plain level write
    host.wr(`AUXCV_ADDR_DAC_CTRL, (16'h1 << `AUXCV_DAC_RAMP_BIT) | (16'h1 << `AUXCV_DAC_EN_BIT) | 16'h0155);
    @(negedge ref_clk);
    chk(16'(dac_level[W-1:0]), 16'h0155);
    stop_test();
  end
endmodule
`default_nettype wire
